/* File: core/hts_defines.svh */
`ifndef HTS_DEFINES_SVH
`define HTS_DEFINES_SVH

// bus target address
`define HTS_TARGET_ADDR 7'h44

// byte framing on the link: bit positions counted in clock bits, plus the index of the last byte of a read
`define HTS_BIT_LAST 4'h7
`define HTS_BIT_ACK 4'h8
`define HTS_TX_LAST 3'h5

// checksum
`define HTS_CRC_POLY 8'h31
`define HTS_CRC_INIT 8'hFF

// timing, in their own units
`define HTS_MCLK_MHZ 40
`define HTS_PU_TIME_US 1500
`define HTS_MEAS_LO_US 2500
`define HTS_MEAS_MED_US 4500
`define HTS_MEAS_HI_US 12500
`define HTS_PER_R0_5_MS 2000
`define HTS_PER_R1_MS 1000
`define HTS_PER_R2_MS 500
`define HTS_PER_R4_MS 250
`define HTS_PER_R10_MS 100

// periodic acquisition commands: rate and repeatability
`define HTS_CMD_P05_HI 16'h2032
`define HTS_CMD_P05_MED 16'h2024
`define HTS_CMD_P05_LO 16'h202F
`define HTS_CMD_P1_HI 16'h2130
`define HTS_CMD_P1_MED 16'h2126
`define HTS_CMD_P1_LO 16'h212D
`define HTS_CMD_P2_HI 16'h2236
`define HTS_CMD_P2_MED 16'h2220
`define HTS_CMD_P2_LO 16'h222B
`define HTS_CMD_P4_HI 16'h2334
`define HTS_CMD_P4_MED 16'h2322
`define HTS_CMD_P4_LO 16'h2329
`define HTS_CMD_P10_HI 16'h2737
`define HTS_CMD_P10_MED 16'h2721
`define HTS_CMD_P10_LO 16'h272A

`endif

/* File: core/hts_pkg.sv */
package hts_pkg;

  typedef enum logic [1:0] {
    HTS_M_POWERUP = 2'h0,
    HTS_M_IDLE = 2'h1,
    HTS_M_MEASURE = 2'h3,
    HTS_M_WAIT = 2'h2
  } hts_meas_state_t;

  typedef enum logic [2:0] {
    HTS_L_ADDR = 3'h0,
    HTS_L_CMD_HI = 3'h1,
    HTS_L_CMD_LO = 3'h3,
    HTS_L_IGNORE = 3'h2,
    HTS_L_TX = 3'h6
  } hts_link_state_t;

  typedef enum logic [1:0] {
    HTS_REP_LO = 2'h0,
    HTS_REP_MED = 2'h1,
    HTS_REP_HI = 2'h2
  } hts_rep_t;

  typedef enum logic [2:0] {
    HTS_RATE_0_5 = 3'h0,
    HTS_RATE_1 = 3'h1,
    HTS_RATE_2 = 3'h2,
    HTS_RATE_4 = 3'h3,
    HTS_RATE_10 = 3'h4
  } hts_rate_t;

endpackage : hts_pkg

/* File: core/hts_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module hts_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : hts_sync
`default_nettype wire

/* File: core/hts_crc8.sv */
`timescale 1ns/10ps
`default_nettype none
`include "hts_defines.svh"
module hts_crc8 (
  input wire logic [15:0] data,
  output logic [7:0] crc
);

  // msb first, no reflection, no final inversion
  always_comb begin
    crc = `HTS_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (crc[7] ^ data[i]) begin
        crc = {crc[6:0], 1'b0} ^ `HTS_CRC_POLY;
      end else begin
        crc = {crc[6:0], 1'b0};
      end
    end
  end

endmodule : hts_crc8
`default_nettype wire

/* File: core/hts_sensor_core.sv */
`timescale 1ns/10ps
`default_nettype none
`include "hts_defines.svh"
// Overview of operation
// RULE1 - answer only bus address 0x44; controller uses it in every header
// RULE2 - wait the power-up interval, accept commands only once idle
// RULE3 - controller opens each transaction with START, closes it with STOP
// RULE4 - enter low-energy idle by itself when not measuring or communicating
// RULE5 - measurement request is START, write header, then two command bytes
// RULE6 - acknowledge each received byte by pulling data low after 8th fall
// RULE7 - conversion starts when final command byte is acknowledged
// RULE8 - single-shot: one temperature then humidity word pair, each with checksum
// RULE9 - three single-shot repeatability levels, each with its own duration
// RULE10 - controller leaves clock free 1ms before reading a single shot
// RULE11 - not-acknowledge a read header while no result is available
// RULE12 - on ready result: ack header, send T, crc, humidity, crc
// RULE13 - next byte only after controller ack; stop after any not-ack
// RULE14 - controller not-acks the humidity checksum then sends STOP
// RULE15 - controller may end a read early with a not-ack
// RULE16 - checksum-less controller still reads temperature crc, aborts after humidity
// RULE17 - periodic command starts a repeating series of result pairs
// RULE18 - periodic codes encode rate and repeatability in two bytes
// RULE19 - periodic rates 0.5, 1, 2, 4, 10 per second, any repeatability
// RULE20 - break command aborts conversion and returns to single-shot mode
// RULE21 - controller waits 1ms between commands
// RULE22 - every sent data word carries an 8-bit checksum
// RULE23 - periodic: nack read with nothing stored; fetch clears storage
// RULE24 - checksum is crc-8, polynomial 0x31, init 0xFF, plain
// RULE25 - a refused read leaves the conversion and pending result untouched
module hts_sensor_core import hts_pkg::*; #(
  parameter int TMR_W = 27,
  parameter int PU_CYC = `HTS_PU_TIME_US * `HTS_MCLK_MHZ,
  parameter int MEAS_LO_CYC = `HTS_MEAS_LO_US * `HTS_MCLK_MHZ,
  parameter int MEAS_MED_CYC = `HTS_MEAS_MED_US * `HTS_MCLK_MHZ,
  parameter int MEAS_HI_CYC = `HTS_MEAS_HI_US * `HTS_MCLK_MHZ,
  parameter int PER_R0_5_CYC = `HTS_PER_R0_5_MS * 1000 * `HTS_MCLK_MHZ,
  parameter int PER_R1_CYC = `HTS_PER_R1_MS * 1000 * `HTS_MCLK_MHZ,
  parameter int PER_R2_CYC = `HTS_PER_R2_MS * 1000 * `HTS_MCLK_MHZ,
  parameter int PER_R4_CYC = `HTS_PER_R4_MS * 1000 * `HTS_MCLK_MHZ,
  parameter int PER_R10_CYC = `HTS_PER_R10_MS * 1000 * `HTS_MCLK_MHZ,
  parameter logic [15:0] CMD_SINGLE_HI = 16'h2400,
  parameter logic [15:0] CMD_SINGLE_MED = 16'h240B,
  parameter logic [15:0] CMD_SINGLE_LO = 16'h2416,
  parameter logic [15:0] CMD_BREAK = 16'h3093,
  parameter logic [15:0] CMD_FETCH = 16'hE000
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [15:0] temp_sample,
  input wire logic [15:0] hum_sample,
  output logic measuring,
  output logic low_power_idle,
  output logic periodic_mode,
  output logic result_ready
);

  // bus conditions: data edges while the clock is high
  logic [1:0] pins_s;
  logic start_reg, start_tgl_reg, stop_tgl_reg;
  logic start_clr_n, frame_open, frame_s;
  logic link_rst_n;

  assign start_clr_n = resetn && scl;
  assign frame_open = start_tgl_reg ^ stop_tgl_reg;

  // a start holds the link in reset until the first clock fall
  always_ff @(negedge sda_in or negedge start_clr_n) begin
    if (!start_clr_n) begin
      start_reg <= 1'b0;
    end else begin
      start_reg <= 1'b1; // RULE3
    end
  end

  // frame open from start to stop; a repeated start does not toggle
  always_ff @(negedge sda_in or negedge resetn) begin
    if (!resetn) begin
      start_tgl_reg <= 1'b0;
    end else if (scl && !frame_open) begin
      start_tgl_reg <= ~start_tgl_reg; // RULE3
    end
  end

  always_ff @(posedge sda_in or negedge resetn) begin
    if (!resetn) begin
      stop_tgl_reg <= 1'b0;
    end else if (scl && frame_open) begin
      stop_tgl_reg <= ~stop_tgl_reg; // RULE3
    end
  end

  // link logic is held in reset outside frames
  assign link_rst_n = resetn && !start_reg && frame_open;

  hts_sync #(.W(2)) u_pin_sync (
    .clk(mclk),
    .rst_n(resetn),
    .ce(ce),
    .d({start_tgl_reg, stop_tgl_reg}),
    .q(pins_s)
  );

  assign frame_s = pins_s[1] ^ pins_s[0];

  // ---------------- link domain (scl) ----------------
  hts_link_state_t link_state_reg;
  logic [3:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic [7:0] rx_byte;
  logic ack_pend_reg;
  logic [2:0] tx_idx_reg;
  logic [7:0] cmd_hi_reg;
  logic [15:0] cmd_word_reg;
  logic cmd_tgl_reg, rd_tgl_reg;
  logic [1:0] stat_s;
  logic pu_ok_s, ready_s;
  logic [47:0] tx_word_reg;
  logic [7:0] tx_byte;
  logic sda_oe_n_reg, sda_out_reg;
  logic pu_done_reg, tx_ready_reg;

  hts_sync #(.W(2)) u_stat_sync (
    .clk(scl),
    .rst_n(link_rst_n),
    .ce(1'b1),
    .d({pu_done_reg, tx_ready_reg}),
    .q(stat_s)
  );

  assign pu_ok_s = stat_s[1];
  assign ready_s = stat_s[0];
  assign rx_byte = {shift_reg, sda_in};

  always_ff @(posedge scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 7'h00;
    end else begin
      bit_cnt_reg <= (bit_cnt_reg == `HTS_BIT_ACK) ? 4'h0 : bit_cnt_reg + 4'h1;
      shift_reg <= {shift_reg[5:0], sda_in};
    end
  end

  always_ff @(posedge scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      link_state_reg <= HTS_L_ADDR;
      ack_pend_reg <= 1'b0;
      tx_idx_reg <= 3'h0;
      cmd_hi_reg <= 8'h00;
    end else if (bit_cnt_reg == `HTS_BIT_LAST) begin
      case (link_state_reg)
        HTS_L_ADDR: begin
          if (rx_byte[7:1] == `HTS_TARGET_ADDR && pu_ok_s) begin // RULE1 RULE2
            if (!rx_byte[0]) begin
              link_state_reg <= HTS_L_CMD_HI; // RULE5
              ack_pend_reg <= 1'b1;
            end else if (ready_s) begin
              link_state_reg <= HTS_L_TX; // RULE12
              ack_pend_reg <= 1'b1;
              tx_idx_reg <= 3'h7; // wraps to byte 0 on the header's ack clock
            end else begin
              link_state_reg <= HTS_L_IGNORE; // RULE11 RULE23 RULE25
              ack_pend_reg <= 1'b0;
            end
          end else begin
            link_state_reg <= HTS_L_IGNORE; // RULE1
            ack_pend_reg <= 1'b0;
          end
        end
        HTS_L_CMD_HI: begin
          cmd_hi_reg <= rx_byte;
          link_state_reg <= HTS_L_CMD_LO;
          ack_pend_reg <= 1'b1; // RULE6
        end
        HTS_L_CMD_LO: begin
          link_state_reg <= HTS_L_IGNORE;
          ack_pend_reg <= 1'b1; // RULE6
        end
        default: begin
          ack_pend_reg <= 1'b0;
        end
      endcase
    end else if (bit_cnt_reg == `HTS_BIT_ACK && link_state_reg == HTS_L_TX) begin
      if (sda_in || tx_idx_reg == `HTS_TX_LAST) begin
        link_state_reg <= HTS_L_IGNORE; // RULE13
      end else begin
        tx_idx_reg <= tx_idx_reg + 3'h1; // RULE13
      end
    end
  end

  // command word and event toggles crossing to mclk; word stays until next command
  always_ff @(posedge scl or negedge resetn) begin
    if (!resetn) begin
      cmd_word_reg <= 16'h0000;
      cmd_tgl_reg <= 1'b0;
      rd_tgl_reg <= 1'b0;
    end else if (link_rst_n && bit_cnt_reg == `HTS_BIT_LAST) begin
      if (link_state_reg == HTS_L_CMD_LO) begin
        cmd_word_reg <= {cmd_hi_reg, rx_byte};
        cmd_tgl_reg <= ~cmd_tgl_reg; // RULE7
      end
      if (link_state_reg == HTS_L_ADDR && rx_byte[7:1] == `HTS_TARGET_ADDR && rx_byte[0]
          && pu_ok_s && ready_s) begin
        rd_tgl_reg <= ~rd_tgl_reg;
      end
    end
  end

  always_comb begin
    case (tx_idx_reg)
      3'h0: tx_byte = tx_word_reg[47:40];
      3'h1: tx_byte = tx_word_reg[39:32];
      3'h2: tx_byte = tx_word_reg[31:24];
      3'h3: tx_byte = tx_word_reg[23:16];
      3'h4: tx_byte = tx_word_reg[15:8];
      default: tx_byte = tx_word_reg[7:0];
    endcase
  end

  // data line changes only while the clock is low
  always_ff @(negedge scl or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_oe_n_reg <= 1'b1;
      sda_out_reg <= 1'b0;
    end else begin
      sda_out_reg <= 1'b0;
      if (bit_cnt_reg == `HTS_BIT_ACK) begin
        sda_oe_n_reg <= !ack_pend_reg; // RULE6
      end else if (link_state_reg == HTS_L_TX) begin
        sda_oe_n_reg <= tx_byte[~bit_cnt_reg[2:0]]; // RULE12
      end else begin
        sda_oe_n_reg <= 1'b1;
      end
    end
  end

  assign sda_oe_n = sda_oe_n_reg;
  assign sda_out = sda_out_reg;

  // ---------------- mclk domain: command events ----------------
  logic [1:0] tgl_s;
  logic cmd_tgl_p_reg, rd_tgl_p_reg;
  logic cmd_evt, rd_evt;

  hts_sync #(.W(2)) u_evt_sync (
    .clk(mclk),
    .rst_n(resetn),
    .ce(ce),
    .d({cmd_tgl_reg, rd_tgl_reg}),
    .q(tgl_s)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cmd_tgl_p_reg <= 1'b0;
      rd_tgl_p_reg <= 1'b0;
    end else if (ce) begin
      cmd_tgl_p_reg <= tgl_s[1];
      rd_tgl_p_reg <= tgl_s[0];
    end
  end

  assign cmd_evt = ce && (tgl_s[1] ^ cmd_tgl_p_reg);
  assign rd_evt = ce && (tgl_s[0] ^ rd_tgl_p_reg);

  // {hit, periodic, rate, repeatability}
  function automatic logic [6:0] decode_cmd(input logic [15:0] c);
    case (c)
      CMD_SINGLE_HI: decode_cmd = {2'b10, HTS_RATE_0_5, HTS_REP_HI}; // RULE9
      CMD_SINGLE_MED: decode_cmd = {2'b10, HTS_RATE_0_5, HTS_REP_MED}; // RULE9
      CMD_SINGLE_LO: decode_cmd = {2'b10, HTS_RATE_0_5, HTS_REP_LO}; // RULE9
      `HTS_CMD_P05_HI: decode_cmd = {2'b11, HTS_RATE_0_5, HTS_REP_HI}; // RULE18
      `HTS_CMD_P05_MED: decode_cmd = {2'b11, HTS_RATE_0_5, HTS_REP_MED}; // RULE18
      `HTS_CMD_P05_LO: decode_cmd = {2'b11, HTS_RATE_0_5, HTS_REP_LO}; // RULE18
      `HTS_CMD_P1_HI: decode_cmd = {2'b11, HTS_RATE_1, HTS_REP_HI}; // RULE18
      `HTS_CMD_P1_MED: decode_cmd = {2'b11, HTS_RATE_1, HTS_REP_MED}; // RULE18
      `HTS_CMD_P1_LO: decode_cmd = {2'b11, HTS_RATE_1, HTS_REP_LO}; // RULE19
      `HTS_CMD_P2_HI: decode_cmd = {2'b11, HTS_RATE_2, HTS_REP_HI}; // RULE19
      `HTS_CMD_P2_MED: decode_cmd = {2'b11, HTS_RATE_2, HTS_REP_MED}; // RULE19
      `HTS_CMD_P2_LO: decode_cmd = {2'b11, HTS_RATE_2, HTS_REP_LO}; // RULE19
      `HTS_CMD_P4_HI: decode_cmd = {2'b11, HTS_RATE_4, HTS_REP_HI}; // RULE19
      `HTS_CMD_P4_MED: decode_cmd = {2'b11, HTS_RATE_4, HTS_REP_MED}; // RULE19
      `HTS_CMD_P4_LO: decode_cmd = {2'b11, HTS_RATE_4, HTS_REP_LO}; // RULE19
      `HTS_CMD_P10_HI: decode_cmd = {2'b11, HTS_RATE_10, HTS_REP_HI}; // RULE19
      `HTS_CMD_P10_MED: decode_cmd = {2'b11, HTS_RATE_10, HTS_REP_MED}; // RULE19
      `HTS_CMD_P10_LO: decode_cmd = {2'b11, HTS_RATE_10, HTS_REP_LO}; // RULE19
      default: decode_cmd = 7'h00;
    endcase
  endfunction : decode_cmd

  function automatic logic [TMR_W-1:0] meas_cycles(input logic [1:0] rep);
    case (rep)
      HTS_REP_HI: meas_cycles = TMR_W'(MEAS_HI_CYC - 1); // RULE9
      HTS_REP_MED: meas_cycles = TMR_W'(MEAS_MED_CYC - 1); // RULE9
      default: meas_cycles = TMR_W'(MEAS_LO_CYC - 1); // RULE9
    endcase
  endfunction : meas_cycles

  function automatic logic [TMR_W-1:0] gap_cycles(input logic [2:0] rate, input logic [1:0] rep);
    int per;
    per = PER_R0_5_CYC;
    case (rate)
      HTS_RATE_1: per = PER_R1_CYC;
      HTS_RATE_2: per = PER_R2_CYC;
      HTS_RATE_4: per = PER_R4_CYC;
      HTS_RATE_10: per = PER_R10_CYC;
      default: per = PER_R0_5_CYC;
    endcase
    gap_cycles = TMR_W'(per - 1) - meas_cycles(rep) - TMR_W'(1); // RULE19
  endfunction : gap_cycles

  // ---------------- mclk domain: measurement engine ----------------
  hts_meas_state_t meas_state_reg;
  logic [TMR_W-1:0] timer_reg;
  logic [6:0] dec;
  logic is_break, is_fetch, start_meas, conv_done;
  logic periodic_reg, stored_valid_reg;
  logic [1:0] rep_reg;
  logic [2:0] rate_reg;
  logic [7:0] crc_t, crc_h;
  logic [47:0] result_word, stored_word_reg;

  assign dec = decode_cmd(cmd_word_reg);
  assign is_break = cmd_evt && cmd_word_reg == CMD_BREAK && meas_state_reg != HTS_M_POWERUP;
  assign is_fetch = cmd_evt && cmd_word_reg == CMD_FETCH && periodic_reg;
  assign start_meas = cmd_evt && dec[6] && meas_state_reg == HTS_M_IDLE; // RULE2
  assign conv_done = ce && meas_state_reg == HTS_M_MEASURE && timer_reg == '0;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meas_state_reg <= HTS_M_POWERUP;
      timer_reg <= TMR_W'(PU_CYC - 1);
    end else if (ce) begin
      case (meas_state_reg)
        HTS_M_POWERUP: begin
          if (timer_reg == '0) begin
            meas_state_reg <= HTS_M_IDLE; // RULE2
          end else begin
            timer_reg <= timer_reg - TMR_W'(1);
          end
        end
        default: begin
          if (is_break) begin
            meas_state_reg <= HTS_M_IDLE; // RULE20
          end else if (start_meas) begin
            meas_state_reg <= HTS_M_MEASURE; // RULE7
            timer_reg <= meas_cycles(dec[1:0]);
          end else if (timer_reg != '0) begin
            timer_reg <= timer_reg - TMR_W'(1);
          end else if (meas_state_reg == HTS_M_MEASURE) begin
            meas_state_reg <= periodic_reg ? HTS_M_WAIT : HTS_M_IDLE; // RULE8 RULE17
            timer_reg <= gap_cycles(rate_reg, rep_reg);
          end else if (meas_state_reg == HTS_M_WAIT) begin
            meas_state_reg <= HTS_M_MEASURE; // RULE17
            timer_reg <= meas_cycles(rep_reg);
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      periodic_reg <= 1'b0;
      rep_reg <= HTS_REP_LO;
      rate_reg <= HTS_RATE_0_5;
    end else if (ce) begin
      if (is_break) begin
        periodic_reg <= 1'b0; // RULE20
      end else if (start_meas) begin
        periodic_reg <= dec[5];
        rate_reg <= dec[4:2];
        rep_reg <= dec[1:0];
      end
    end
  end

  hts_crc8 u_crc_t (
    .data(temp_sample),
    .crc(crc_t)
  );

  hts_crc8 u_crc_h (
    .data(hum_sample),
    .crc(crc_h)
  );

  assign result_word = {temp_sample, crc_t, hum_sample, crc_h}; // RULE8 RULE22 RULE24

  // result hand-off; the set of a fresh result wins over a read that clears it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_word_reg <= 48'h000000000000;
      stored_word_reg <= 48'h000000000000;
      tx_ready_reg <= 1'b0;
      stored_valid_reg <= 1'b0;
    end else if (ce) begin
      if (rd_evt || (start_meas && !dec[5])) begin
        tx_ready_reg <= 1'b0;
      end
      if (is_fetch || is_break || start_meas) begin
        stored_valid_reg <= 1'b0; // RULE23
      end
      if (is_fetch && stored_valid_reg) begin
        tx_word_reg <= stored_word_reg; // RULE23
        tx_ready_reg <= 1'b1;
      end
      if (conv_done && !is_break) begin
        if (periodic_reg) begin
          stored_word_reg <= result_word; // RULE17
          stored_valid_reg <= 1'b1;
        end else begin
          tx_word_reg <= result_word; // RULE8
          tx_ready_reg <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pu_done_reg <= 1'b0;
      measuring <= 1'b0;
      low_power_idle <= 1'b0;
      periodic_mode <= 1'b0;
      result_ready <= 1'b0;
    end else if (ce) begin
      pu_done_reg <= meas_state_reg != HTS_M_POWERUP;
      measuring <= meas_state_reg == HTS_M_MEASURE;
      low_power_idle <= (meas_state_reg == HTS_M_IDLE || meas_state_reg == HTS_M_WAIT)
                        && !frame_s; // RULE4
      periodic_mode <= periodic_reg;
      result_ready <= tx_ready_reg;
    end
  end

endmodule : hts_sensor_core
`default_nettype wire

/* File: bench/hts_sensor_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module hts_sensor_monitor #(
  parameter int PU_CYC = 20,
  parameter int MEAS_HI_CYC = 50
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic sda_out,
  input wire logic measuring,
  input wire logic low_power_idle,
  input wire logic periodic_mode,
  input wire logic result_ready
);
  logic [19:0] pu_cnt_reg;
  logic [19:0] run_cnt_reg;

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) pu_cnt_reg <= 20'h0;
    else if (ce && pu_cnt_reg < PU_CYC) pu_cnt_reg <= pu_cnt_reg + 20'h1;
  end

  // length of the current conversion
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) run_cnt_reg <= 20'h0;
    else run_cnt_reg <= measuring ? run_cnt_reg + 20'h1 : 20'h0;
  end

  sequence s_stops;
    ##[0:3] !measuring;
  endsequence
  sequence s_starts;
    ##[0:4] measuring;
  endsequence

  drive_low_a: assert property (!sda_out)
    else $error("data out value not low");
  idle_excl_a: assert property (measuring |-> !low_power_idle)
    else $error("idle while measuring");
  powerup_quiet_a: assert property (pu_cnt_reg < PU_CYC |->
    !measuring && !periodic_mode && !result_ready)
    else $error("activity during power-up");
  ready_cause_a: assert property ($rose(result_ready) |-> periodic_mode ||
    $past(measuring) || $past(measuring, 2) || $past(measuring, 3))
    else $error("result without conversion");
  meas_len_a: assert property (run_cnt_reg <= MEAS_HI_CYC + 4)
    else $error("conversion too long");
  periodic_go_a: assert property ($rose(periodic_mode) |-> s_starts)
    else $error("periodic mode without conversion");
  ready_excl_a: assert property (measuring && $past(measuring) &&
    !periodic_mode |-> !result_ready)
    else $error("result ready during conversion");
  break_abort_a: assert property ($fell(periodic_mode) |-> s_stops)
    else $error("conversion kept after break");
endmodule : hts_sensor_monitor

bind hts_sensor_core hts_sensor_monitor #(
  .PU_CYC(PU_CYC),
  .MEAS_HI_CYC(MEAS_HI_CYC)
) u_mon (
  .mclk(mclk),
  .resetn(resetn),
  .ce(ce),
  .sda_out(sda_out),
  .measuring(measuring),
  .low_power_idle(low_power_idle),
  .periodic_mode(periodic_mode),
  .result_ready(result_ready)
);
`default_nettype wire

/* File: bench/hts_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none
module hts_bus_model (
  output var logic scl,
  output var logic sda_pull_n,
  input wire logic sda_line
);
  localparam int HALF = 3;
  localparam int HOLD = 150;

  initial begin
    scl = 1'b1;
    sda_pull_n = 1'b1;
  end

  // clock stands still between frames
  task automatic bus_start();
    sda_pull_n = 1'b0;
    #HOLD;
    scl = 1'b0;
  endtask : bus_start

  task automatic bus_stop();
    sda_pull_n = 1'b0;
    #HALF;
    scl = 1'b1;
    #HOLD;
    sda_pull_n = 1'b1;
    #HOLD;
  endtask : bus_stop

  task automatic pulse(output logic b);
    #HALF;
    scl = 1'b1;
    b = sda_line;
    #HALF;
    scl = 1'b0;
  endtask : pulse

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_pull_n = b[i];
      pulse(s);
    end
    sda_pull_n = 1'b1;
    pulse(s);
    ack = !s;
  endtask : put_byte

  task automatic get_byte(input logic ack_it, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(b[i]);
    sda_pull_n = !ack_it;
    pulse(s);
    sda_pull_n = 1'b1;
  endtask : get_byte
endmodule : hts_bus_model
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "hts_defines.svh"
module testbench;
  localparam int GAP = 40;
  localparam logic [15:0] SCODE [3] = '{16'h2400, 16'h240B, 16'h2416};
  localparam int SLEN [3] = '{500, 400, 300};
  localparam logic [15:0] PCODE [15] = '{`HTS_CMD_P05_HI, `HTS_CMD_P05_MED,
    `HTS_CMD_P05_LO, `HTS_CMD_P1_HI, `HTS_CMD_P1_MED, `HTS_CMD_P1_LO,
    `HTS_CMD_P2_HI, `HTS_CMD_P2_MED, `HTS_CMD_P2_LO, `HTS_CMD_P4_HI,
    `HTS_CMD_P4_MED, `HTS_CMD_P4_LO, `HTS_CMD_P10_HI, `HTS_CMD_P10_MED,
    `HTS_CMD_P10_LO};
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic [15:0] t_smp = 16'h0;
  logic [15:0] h_smp = 16'h0;
  logic scl;
  logic sda_pull_n;
  logic sda_out;
  logic sda_oe_n;
  logic meas;
  logic lpi;
  logic pm;
  logic rdy;
  wire logic sda_line;
  int run = 0;
  int last_run = 0;
  int failures = 0;
  int n_checks = 0;

  assign sda_line = (sda_oe_n | sda_out) & sda_pull_n;
  always #12.5 mclk = ~mclk;

  always @(posedge mclk) begin
    if (meas === 1'b1) run <= run + 1;
    else if (run != 0) begin
      last_run <= run;
      run <= 0;
    end
  end

  hts_sensor_core #(.PU_CYC(200), .MEAS_LO_CYC(300), .MEAS_MED_CYC(400),
    .MEAS_HI_CYC(500)) dut (
    .mclk(mclk), .resetn(resetn), .ce(ce), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .temp_sample(t_smp),
    .hum_sample(h_smp), .measuring(meas), .low_power_idle(lpi),
    .periodic_mode(pm), .result_ready(rdy));

  hts_bus_model bfm (.scl(scl), .sda_pull_n(sda_pull_n), .sda_line(sda_line));

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction : crc8

  task automatic close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] adr, input logic [15:0] c, output logic ok);
    logic a0;
    logic a1 = 1'b0;
    logic a2 = 1'b0;
    bfm.bus_start();
    bfm.put_byte(adr, a0);
    if (a0) bfm.put_byte(c[15:8], a1);
    if (a1) bfm.put_byte(c[7:0], a2);
    bfm.bus_stop();
    ok = a2;
    repeat (GAP) @(posedge mclk);
  endtask : cmd

  task automatic rd(input int n, input logic hdr, input logic [15:0] t, input logic [15:0] h);
    logic a;
    logic [7:0] b;
    logic [7:0] e [6];
    e = '{t[15:8], t[7:0], crc8(t), h[15:8], h[7:0], crc8(h)};
    bfm.bus_start();
    bfm.put_byte(8'h89, a);
    chk(a === hdr, "read header answer");
    for (int i = 0; i < n && a; i++) begin
      bfm.get_byte(i < n - 1, b);
      chk(b === e[i], "read byte");
    end
    bfm.bus_stop();
    repeat (GAP) @(posedge mclk);
  endtask : rd

  task automatic wait_rdy();
    for (int i = 0; i < 3000 && rdy !== 1'b1; i++) @(posedge mclk);
    if (rdy !== 1'b1) begin
      chk(1'b0, "result never ready");
      close_out();
    end
  endtask : wait_rdy

  task automatic s_powerup();
    logic ok;
    cmd(8'h88, SCODE[0], ok);
    chk(!ok && meas === 1'b0, "command taken in power-up");
    ce <= 1'b0;
    repeat (150) @(posedge mclk);
    ce <= 1'b1;
    cmd(8'h88, SCODE[0], ok);
    chk(!ok, "power-up ran on with clock enable low");
    repeat (200) @(posedge mclk);
  endtask : s_powerup

  task automatic s_address();
    logic ok;
    cmd(8'h8A, SCODE[2], ok);
    chk(!ok && meas === 1'b0, "foreign address answered");
  endtask : s_address

  task automatic s_single();
    logic ok;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      t_smp <= 16'h6A4C + 16'(i);
      h_smp <= 16'hB1E7 - 16'(i);
      cmd(8'h88, SCODE[i], ok);
      chk(ok && meas === 1'b1 && lpi === 1'b0, "single shot not started");
      rd(6, 1'b0, t_smp, h_smp);
      wait_rdy();
      @(posedge mclk);
      chk(last_run >= SLEN[i] - 2 && last_run <= SLEN[i] + 2, "duration");
      chk(lpi === 1'b1, "no idle after conversion");
      rd(6, 1'b1, t_smp, h_smp);
    end
  endtask : s_single

  task automatic s_abort();
    logic ok;
    cmd(8'h88, SCODE[2], ok);
    wait_rdy();
    rd(2, 1'b1, t_smp, h_smp);
    rd(0, 1'b0, t_smp, h_smp);
    cmd(8'h88, SCODE[2], ok);
    wait_rdy();
    rd(5, 1'b1, t_smp, h_smp);
  endtask : s_abort

  task automatic s_periodic();
    logic ok;
    logic ob;
    for (int i = 0; i < 15; i++) begin
      cmd(8'h88, PCODE[i], ok);
      chk(ok && pm === 1'b1, "periodic code not taken");
      cmd(8'h88, 16'h3093, ob);
      chk(ob && pm === 1'b0 && meas === 1'b0, "break not taken");
    end
  endtask : s_periodic

  task automatic s_fetch();
    logic ok;
    cmd(8'h88, `HTS_CMD_P10_HI, ok);
    repeat (600) @(posedge mclk);
    rd(6, 1'b0, t_smp, h_smp);
    cmd(8'h88, 16'hE000, ok);
    rd(6, 1'b1, t_smp, h_smp);
    cmd(8'h88, 16'hE000, ok);
    rd(6, 1'b0, t_smp, h_smp);
    cmd(8'h88, 16'h3093, ok);
    chk(pm === 1'b0, "periodic kept after break");
  endtask : s_fetch

  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    s_powerup();
    s_address();
    s_single();
    s_abort();
    s_periodic();
    s_fetch();
    close_out();
  end
endmodule : testbench
`default_nettype wire
